//--- design/sicb_top.sv
// The implementer's own choices: the register addresses and strobed register access.
`timescale 1ns/100ps
`include "sicb_params.svh"
module sicb_top (
    input wire logic core_clk_in,
    input wire logic rstn_in,
    input wire logic [`SICB_ADDR_W-1:0] addr_in,
    input wire logic [15:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [15:0] rdata_out,
    input wire logic int_clk_in,
    input wire logic debug_freeze_in,
    input wire logic [15:0] data_bus_in,
    input wire logic clock_source_select_pin_in,
    input wire logic clk_pin_is_port_in,
    input wire logic internal_xfer_in,
    input wire logic [15:0] internal_data_in,
    input wire logic bus_grant_in,
    output logic system_clock_output_pin_out,
    output logic system_clock_output_pin_oe_n_out,
    output logic timer_count_en_out,
    output logic bus_watch_en_out,
    output logic external_master_access_status_out,
    output logic [15:0] show_data_out,
    output logic show_data_oe_n_out,
    output logic periph_select_block_out,
    output logic ext_arb_allow_out,
    output logic internal_halt_out,
    output logic clock_source_select_port_out
);
    typedef struct packed {
        logic [4:0] cfg;
        logic access;
        logic in_reset;
        logic [15:0] rdata;
        logic clk_pin;
        logic clk_oe_n;
        logic tmr_en;
        logic bw_en;
        logic [15:0] show_data;
        logic show_oe_n;
        logic blk;
        logic arb;
        logic halt;
        logic port_bit;
    } sicb_state_t;
    sicb_state_t st_r, st_nxt;
    logic [15:0] data_sync;
    logic clk_pin_sync;
    // raw pins go straight into the flops: no gate may sit in front of a synchroniser,
    // so the data word is only used by the in-reset capture further down
    // this synchroniser ignores reset so the strap level is already through both stages
    // by the first edge after release; the cost is 32 flops toggling on a busy bus
    sicb_sync #(.W(16)) u_data_sync (
        .core_clk_in(core_clk_in),
        .rstn_in(1'b1),
        .d_in(data_bus_in),
        .q_out(data_sync)
    );
    // clock-mode pin synchronised raw; it only counts while it acts as a port bit
    sicb_sync #(.W(1)) u_clk_sync (
        .core_clk_in(core_clk_in),
        .rstn_in(rstn_in),
        .d_in(clock_source_select_pin_in),
        .q_out(clk_pin_sync)
    );
    // next state
    always_comb begin
        sicb_pkg::sicb_show_t sel;
        sel = sicb_pkg::sicb_show_t'(st_r.cfg[`SICB_BIT_SHOW_HI:`SICB_BIT_SHOW_LO]);
        st_nxt = st_r;
        st_nxt.rdata = 16'h0000;
        if (wr_in && addr_in == `SICB_CFG_OFS) begin
            st_nxt.cfg = wdata_in[4:0];
        end
        if (rd_in) begin
            case (addr_in)
                `SICB_CFG_OFS: st_nxt.rdata = {11'h000, st_r.cfg};
                // access status is read only; writes to this offset are ignored
                `SICB_STAT_OFS: st_nxt.rdata = {15'h0000, st_r.access};
                default: st_nxt.rdata = 16'h0000;
            endcase
        end
        // status bit is held at zero in reset, takes the synchronised data bit on the first edge after release, frozen after
        if (st_r.in_reset) begin
            st_nxt.access = data_sync[`SICB_DATA_BIT_ACCESS];
        end
        st_nxt.in_reset = 1'b0;
        st_nxt.clk_pin = int_clk_in & ~st_r.cfg[`SICB_BIT_CLK_OFF];
        st_nxt.clk_oe_n = st_r.cfg[`SICB_BIT_CLK_OFF];
        st_nxt.tmr_en = ~(debug_freeze_in & st_r.cfg[`SICB_BIT_FRZ_TMR]);
        st_nxt.bw_en = ~(debug_freeze_in & st_r.cfg[`SICB_BIT_FRZ_BW]);
        st_nxt.show_oe_n = 1'b1;
        st_nxt.blk = 1'b0;
        st_nxt.halt = 1'b0;
        st_nxt.arb = 1'b1;
        case (sel)
            sicb_pkg::SICB_SHOW_OFF: st_nxt.arb = 1'b1;
            sicb_pkg::SICB_SHOW_NOARB: st_nxt.arb = 1'b0;
            sicb_pkg::SICB_SHOW_ARB: st_nxt.arb = 1'b1;
            sicb_pkg::SICB_SHOW_HALT: st_nxt.halt = bus_grant_in;
            default: st_nxt.arb = 1'b1;
        endcase
        // mirror internal transfers; peripherals kept deselected so they never contend
        if (sel != sicb_pkg::SICB_SHOW_OFF && internal_xfer_in) begin
            st_nxt.show_oe_n = 1'b0;
            st_nxt.show_data = internal_data_in;
            st_nxt.blk = 1'b1;
        end
        st_nxt.port_bit = clk_pin_sync & clk_pin_is_port_in;
    end
    // register the whole state; reset takes constants and marks the sampling window
    always_ff @(posedge core_clk_in) begin
        if (!rstn_in) begin
            st_r <= '0;
            st_r.cfg <= `SICB_CFG_RESET;
            st_r.in_reset <= 1'b1;
            st_r.clk_oe_n <= 1'b0;
            st_r.tmr_en <= 1'b1;
            st_r.bw_en <= 1'b1;
            st_r.show_oe_n <= 1'b1;
            st_r.arb <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end
    assign rdata_out = st_r.rdata;
    assign system_clock_output_pin_out = st_r.clk_pin;
    assign system_clock_output_pin_oe_n_out = st_r.clk_oe_n;
    assign timer_count_en_out = st_r.tmr_en;
    assign bus_watch_en_out = st_r.bw_en;
    assign external_master_access_status_out = st_r.access;
    assign show_data_out = st_r.show_data;
    assign show_data_oe_n_out = st_r.show_oe_n;
    assign periph_select_block_out = st_r.blk;
    assign ext_arb_allow_out = st_r.arb;
    assign internal_halt_out = st_r.halt;
    assign clock_source_select_port_out = st_r.port_bit;

    clk_off_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        $past(st_r.cfg[0]) |-> system_clock_output_pin_oe_n_out)
        else $error("clock pin driven while disabled");
    tmr_freeze_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        (debug_freeze_in && st_r.cfg[1]) |=> !timer_count_en_out)
        else $error("timers run during freeze");
    bw_freeze_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        (!debug_freeze_in) |=> bus_watch_en_out)
        else $error("bus watch off without freeze");
    access_hold_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        (!st_r.in_reset && !$past(st_r.in_reset)) |-> $stable(external_master_access_status_out))
        else $error("access status changed after reset");
    show_drive_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        (st_r.cfg[4:3] != 2'h0 && internal_xfer_in) |=> (!show_data_oe_n_out && periph_select_block_out))
        else $error("show cycle not driven");
    show_off_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        (st_r.cfg[4:3] == 2'h0) |=> (show_data_oe_n_out && ext_arb_allow_out))
        else $error("show while disabled");
    arb_refuse_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        (st_r.cfg[4:3] == 2'h1) |=> !ext_arb_allow_out)
        else $error("arbitration allowed in mode 01");
    halt_grant_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        (st_r.cfg[4:3] == 2'h3 && bus_grant_in) |=> (internal_halt_out && ext_arb_allow_out))
        else $error("no halt on grant");

    // each output is a one-cycle registered copy of its cause, so checks look one edge on
    // clock pin is driven whenever the disable bit is clear
    clk_drive_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        (!st_r.cfg[0]) |=> !system_clock_output_pin_oe_n_out)
        else $error("clock pin floated while enabled");
    // driven clock pin follows the internal source
    clk_follow_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        (!st_r.cfg[0]) |=> (system_clock_output_pin_out == $past(int_clk_in)))
        else $error("clock pin does not follow source");
    // floated clock pin carries no level into the pad
    clk_quiet_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        st_r.cfg[0] |=> !system_clock_output_pin_out)
        else $error("clock level present while floated");
    // timers keep counting unless both freeze and the bit are set
    tmr_run_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        (!debug_freeze_in || !st_r.cfg[1]) |=> timer_count_en_out)
        else $error("timers stopped without freeze");
    // bus watch stops under freeze when asked
    bw_stop_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        (debug_freeze_in && st_r.cfg[2]) |=> !bus_watch_en_out)
        else $error("bus watch runs during freeze");
    // bus watch keeps running under freeze when the bit is clear
    bw_run_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        (debug_freeze_in && !st_r.cfg[2]) |=> bus_watch_en_out)
        else $error("bus watch stopped with bit clear");
    // status takes the synchronised strap in the capture window
    access_cap_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        st_r.in_reset |=> (external_master_access_status_out == $past(data_sync[`SICB_DATA_BIT_ACCESS])))
        else $error("access status not captured");
    // mirrored word is the internal transfer's data
    show_data_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        (st_r.cfg[4:3] != 2'h0 && internal_xfer_in) |=> (show_data_out == $past(internal_data_in)))
        else $error("show data wrong");
    // no transfer, no drive and no deselect
    show_idle_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        (!internal_xfer_in) |=> (show_data_oe_n_out && !periph_select_block_out))
        else $error("show drive without transfer");
    // show off never blocks peripherals nor halts
    off_quiet_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        (st_r.cfg[4:3] == 2'h0) |=> (!periph_select_block_out && !internal_halt_out))
        else $error("deselect or halt while show off");
    // upper two select codes keep arbitration open
    arb_allow_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        st_r.cfg[4] |=> ext_arb_allow_out)
        else $error("arbitration refused in mode 1x");
    // halt only in mode 11 with a grant
    halt_only_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        (st_r.cfg[4:3] != 2'h3 || !bus_grant_in) |=> !internal_halt_out)
        else $error("halt without grant in mode 11");
    // port value reads zero when the pin is not a port
    port_zero_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        (!clk_pin_is_port_in) |=> !clock_source_select_port_out)
        else $error("port value while not a port");
    // read data stand for one cycle only
    rdata_idle_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        (!rd_in) |=> (rdata_out == 16'h0000))
        else $error("read data without read");
endmodule

//--- design/sicb_params.svh
// Behaviour
// - clock-out disable bit floats clock pin
// - freeze bit stops timer counters in debug
// - freeze bit disables bus watch in debug
// - read-only access status captured from data bit 11
// - show cycles mirror internal transfers externally
// - select 00: no show, arbitration allowed
// - select 01: show, arbitration refused
// - data sampled only in the reset window; clock pin as port
// - 10 show plus arbitration; 11 also halts on grant
`ifndef SICB_PARAMS_SVH
`define SICB_PARAMS_SVH
`define SICB_ADDR_W 4
`define SICB_CFG_OFS 4'h0
`define SICB_STAT_OFS 4'h1
`define SICB_BIT_CLK_OFF 0
`define SICB_BIT_FRZ_TMR 1
`define SICB_BIT_FRZ_BW 2
`define SICB_BIT_SHOW_LO 3
`define SICB_BIT_SHOW_HI 4
`define SICB_DATA_BIT_ACCESS 11
`define SICB_CFG_RESET 5'h00
`endif

//--- design/sicb_pkg.sv
package sicb_pkg;
    typedef enum logic [1:0] {
        SICB_SHOW_OFF,
        SICB_SHOW_NOARB,
        SICB_SHOW_ARB,
        SICB_SHOW_HALT
    } sicb_show_t;
endpackage

//--- design/sicb_sync.sv
`timescale 1ns/100ps
// two-stage synchroniser, one per bit
module sicb_sync #(
    parameter int W = 1
) (
    input wire logic core_clk_in,
    input wire logic rstn_in,
    input wire logic [W-1:0] d_in,
    output logic [W-1:0] q_out
);
    logic [W-1:0] meta_r;
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            always_ff @(posedge core_clk_in) begin
                if (!rstn_in) begin
                    meta_r[i] <= 1'b0;
                    q_out[i] <= 1'b0;
                end else begin
                    meta_r[i] <= d_in[i];
                    q_out[i] <= meta_r[i];
                end
            end
        end
    endgenerate
endmodule

//--- dv/sicb_bus_model.sv
`timescale 1ns/100ps
// far side of the external bus: strap pins during reset, a live bus after
module sicb_bus_model (
    input wire logic core_clk_in,
    input wire logic rstn_in,
    input wire logic strap_in,
    input wire logic show_oe_n_in,
    input wire logic [15:0] show_data_in,
    input wire logic blk_in,
    output logic [15:0] data_bus_out,
    output logic [15:0] seen_data_out,
    output logic periph_sel_out
);
    logic [15:0] walk_r;
    logic was_rst_r;
    // strap stays one edge past release; then the bus keeps moving so stale levels never look valid
    always_ff @(posedge core_clk_in) begin
        was_rst_r <= rstn_in;
        walk_r <= was_rst_r ? ~walk_r : 16'h0000;
        if (!show_oe_n_in) begin
            seen_data_out <= show_data_in;
        end
    end
    assign data_bus_out = (rstn_in && was_rst_r) ? walk_r : {4'h0, strap_in, 11'h000};
    assign periph_sel_out = !blk_in;
endmodule

//--- dv/sys_integration_config_bits_test.sv
`timescale 1ns/100ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_fail++; $display("ERROR %0t bad %h", $time, a); end end
module sys_integration_config_bits_test;
    logic core_clk_in = 0, rstn_in = 0, wr_in = 0, rd_in = 0, int_clk_in = 0, frz = 0;
    logic pin = 0, port = 0, xfer = 0, grant = 0, strap = 1;
    logic [3:0] addr_in = 4'h0;
    logic [15:0] wdata_in = 16'h0000, idata = 16'hA5C3, rv, data_bus, show_data, seen, rdata;
    logic clk_pin, clk_oe_n, tmr_en, bw_en, acc, show_oe_n, blk, arb, halt, port_out, psel;
    int n_fail = 0, checks_done = 0;
    sicb_top dut (.core_clk_in(core_clk_in), .rstn_in(rstn_in), .addr_in(addr_in), .wdata_in(wdata_in),
        .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata), .int_clk_in(int_clk_in), .debug_freeze_in(frz),
        .data_bus_in(data_bus), .clock_source_select_pin_in(pin), .clk_pin_is_port_in(port),
        .internal_xfer_in(xfer), .internal_data_in(idata), .bus_grant_in(grant),
        .system_clock_output_pin_out(clk_pin), .system_clock_output_pin_oe_n_out(clk_oe_n),
        .timer_count_en_out(tmr_en), .bus_watch_en_out(bw_en), .external_master_access_status_out(acc),
        .show_data_out(show_data), .show_data_oe_n_out(show_oe_n), .periph_select_block_out(blk),
        .ext_arb_allow_out(arb), .internal_halt_out(halt), .clock_source_select_port_out(port_out));
    sicb_bus_model bus (.core_clk_in(core_clk_in), .rstn_in(rstn_in), .strap_in(strap),
        .show_oe_n_in(show_oe_n), .show_data_in(show_data), .blk_in(blk), .data_bus_out(data_bus),
        .seen_data_out(seen), .periph_sel_out(psel));
    // 40 MHz
    initial forever #12.5 core_clk_in = ~core_clk_in;
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk_in);
    endtask
    task automatic settle(input int n);
        tick(n);
        #1;
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        tick(1);
        addr_in <= a; wdata_in <= d; wr_in <= 1'b1;
        tick(1);
        wr_in <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        tick(1);
        addr_in <= a; rd_in <= 1'b1;
        settle(1);
        d = rdata;
        rd_in <= 1'b0;
    endtask
    task automatic t_status;
        rd(4'h1, rv); `CHK(rv, 16'h0001)
        wr(4'h1, 16'h0000); rd(4'h1, rv); `CHK(rv, 16'h0001)
        rd(4'hF, rv); `CHK(rv, 16'h0000)
    endtask
    task automatic t_clock;
        int_clk_in <= 1'b1;
        settle(2); `CHK({clk_pin, clk_oe_n}, 2'b10)
        wr(4'h0, 16'h0001); settle(1); `CHK(clk_oe_n, 1'b1)
        rd(4'h0, rv); `CHK(rv, 16'h0001)
    endtask
    task automatic t_freeze;
        frz <= 1'b1;
        wr(4'h0, 16'h0002); settle(1); `CHK({tmr_en, bw_en}, 2'b01)
        wr(4'h0, 16'h0004); settle(1); `CHK({tmr_en, bw_en}, 2'b10)
        wr(4'h0, 16'h0000); settle(1); `CHK({tmr_en, bw_en}, 2'b11)
        frz <= 1'b0;
    endtask
    // every show select code with a transfer in flight and the grant given
    task automatic t_show;
        for (int m = 0; m < 4; m++) begin
            wr(4'h0, 16'(m << 3));
            xfer <= 1'b1; grant <= 1'b1;
            settle(2);
            `CHK({show_oe_n, blk}, (m == 0) ? 2'b10 : 2'b01)
            `CHK({arb, halt}, {m != 1, m == 3})
            if (m != 0) `CHK(seen, idata)
            `CHK(psel, m == 0)
            xfer <= 1'b0; grant <= 1'b0;
        end
    endtask
    // pin value reaches the port output only while the pin serves as a port bit
    task automatic t_port;
        tick(1); port <= 1'b1; pin <= 1'b1;
        settle(4); `CHK(port_out, 1'b1)
        tick(1); port <= 1'b0;
        settle(4); `CHK(port_out, 1'b0)
    endtask
    task automatic conclude;
        if (n_fail == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // strap stands from time zero, so two reset cycles fill both synchroniser stages
    initial begin
        tick(2);
        rstn_in <= 1'b1;
        tick(1);
        t_status(); t_clock(); t_freeze(); t_show(); t_port();
        conclude();
    end
    initial begin
        #20us;
        n_fail++;
        conclude();
    end
endmodule
